// File: verilog/sltp_defs.svh
// register map, field positions, reset values and timing counts
`ifndef SLTP_DEFS_SVH
`define SLTP_DEFS_SVH

`define SLTP_ADDR_W 8
`define SLTP_ADDR_CTRL 8'h00
`define SLTP_ADDR_STATUS 8'h04

`define SLTP_F_MODE_LSB 0
`define SLTP_F_MODE_MSB 3
`define SLTP_F_TEST_LSB 4
`define SLTP_F_TEST_MSB 6
`define SLTP_F_ALT 7
`define SLTP_F_LANES_LSB 8
`define SLTP_F_LANES_MSB 9
`define SLTP_F_FEC 10
`define SLTP_F_FULL_PD 11
`define SLTP_F_LINK_EN 12
`define SLTP_F_CHEN_LSB 14
`define SLTP_F_CHEN_MSB 15
`define SLTP_CTRL_RESET 32'h0000_C00C
`define SLTP_CTRL_MASK 32'h0000_DFFF

`define SLTP_MODE_MIN 4'hC
`define SLTP_MODE_8B10B 4'hD
`define SLTP_MODE_QUAD 4'hE
`define SLTP_MODE_MAX 4'hF

`define SLTP_LANES_8 2'h0
`define SLTP_LANES_4 2'h1
`define SLTP_LANES_2 2'h2

`define SLTP_RESP_OKAY 2'h0
`define SLTP_RESP_SLVERR 2'h2

`define SLTP_CLK_NS 25
`define SLTP_FLUSH_NS 2000
`define SLTP_FLUSH_CYC ((`SLTP_FLUSH_NS + `SLTP_CLK_NS - 1) / `SLTP_CLK_NS)

`endif

// File: verilog/sltp_pkg.sv
// types shared by the lane map and test pattern logic
package sltp_pkg;

  typedef enum logic [2:0] {
    SLTP_TEST_NONE = 3'h0,
    SLTP_TEST_PRBS7 = 3'h1,
    SLTP_TEST_PRBS9 = 3'h2,
    SLTP_TEST_PRBS15 = 3'h3,
    SLTP_TEST_PRBS23 = 3'h4,
    SLTP_TEST_PRBS31 = 3'h5,
    SLTP_TEST_CLOCK = 3'h6,
    SLTP_TEST_RAMP = 3'h7
  } sltp_test_t;

  typedef enum logic [2:0] {
    SLTP_PWR_RUN = 3'b001,
    SLTP_PWR_DOWN = 3'b010,
    SLTP_PWR_FLUSH = 3'b100
  } sltp_pwr_t;

endpackage : sltp_pkg

// File: verilog/sltp_pack_if.sv
// carrier between the lane controller and the sample packer
`timescale 1ns/100ps
interface sltp_pack_if;
  logic [3:0] link_mode;
  logic run;
  logic take;
  logic [2:0] oct_idx;
  logic [63:0] octets;

  modport packer (
    input link_mode,
    input run,
    output take,
    output oct_idx,
    output octets
  );

  modport ctrl (
    output link_mode,
    output run,
    input take,
    input oct_idx,
    input octets
  );
endinterface : sltp_pack_if

// File: verilog/sltp_prbs.sv
// one lane prbs generator, eight bits per clock, msb first
`timescale 1ns/100ps
module sltp_prbs #(
  parameter logic [30:0] SEED = 31'h0000_0001
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reload,
  input wire logic advance,
  input wire logic [2:0] sel,
  output logic [7:0] octet
);

  logic [30:0] state_reg;
  logic [30:0] state_next;
  logic [7:0] bits_next;

  // tap pair as distances back: y[n] = y[n-a] ^ y[n-b]
  function automatic logic [9:0] taps(input logic [2:0] s);
    case (s)
      sltp_pkg::SLTP_TEST_PRBS9: taps = {5'd5, 5'd9};
      sltp_pkg::SLTP_TEST_PRBS15: taps = {5'd14, 5'd15};
      sltp_pkg::SLTP_TEST_PRBS23: taps = {5'd18, 5'd23};
      sltp_pkg::SLTP_TEST_PRBS31: taps = {5'd28, 5'd31};
      default: taps = {5'd6, 5'd7};
    endcase
  endfunction : taps

  always_comb begin
    logic [9:0] t;
    logic b;
    t = taps(sel);
    b = 1'b0;
    state_next = state_reg;
    bits_next = 8'h00;
    for (int i = 0; i < 8; i++) begin
      b = state_next[t[9:5] - 5'd1] ^ state_next[t[4:0] - 5'd1];
      state_next = {state_next[29:0], b};
      bits_next[7 - i] = b;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || reload) begin
      state_reg <= SEED;
      octet <= 8'h00;
    end else if (advance) begin
      state_reg <= state_next;
      octet <= bits_next;
    end
  end

endmodule : sltp_prbs

// File: verilog/sltp_packer.sv
// packs one frame of samples into per lane octets
`timescale 1ns/100ps
`include "sltp_defs.svh"
module sltp_packer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [191:0] sample_a,
  input wire logic [191:0] sample_b,
  input wire logic [47:0] sample_c,
  input wire logic [47:0] sample_d,
  sltp_pack_if.packer pk
);

  logic [191:0] fa_reg;
  logic [191:0] fb_reg;
  logic [191:0] fc_reg;
  logic [191:0] fd_reg;
  logic [2:0] idx_reg;
  logic take_reg;
  logic [2:0] last_idx;
  logic [2:0] oct_sel;

  function automatic logic [11:0] smp(input logic [191:0] bus, input int j);
    smp = bus[12 * j +: 12];
  endfunction : smp

  always_comb begin
    case (pk.link_mode)
      `SLTP_MODE_MIN: last_idx = 3'd0;
      `SLTP_MODE_8B10B: last_idx = 3'd4;
      default: last_idx = 3'd2;
    endcase
    // index lags one so each frame leaves whole, octet 0 first
    oct_sel = (idx_reg == 3'd0) ? last_idx : idx_reg - 3'd1;
  end

  // frame captured at octet 0, take high the cycle after
  always_ff @(posedge aclk) begin
    if (!aresetn || !pk.run) begin
      idx_reg <= 3'd0;
      take_reg <= 1'b0;
    end else begin
      take_reg <= (idx_reg == 3'd0);
      idx_reg <= (idx_reg >= last_idx) ? 3'd0 : idx_reg + 3'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fa_reg <= 192'h0;
      fb_reg <= 192'h0;
      fc_reg <= 192'h0;
      fd_reg <= 192'h0;
    end else if (pk.run && idx_reg == 3'd0) begin
      fa_reg <= sample_a;
      fb_reg <= sample_b;
      fc_reg <= {144'h0, sample_c};
      fd_reg <= {144'h0, sample_d};
    end
  end

  always_comb begin
    logic [191:0] bus;
    logic [39:0] w;
    int k;
    bus = fa_reg;
    w = 40'h0;
    k = 0;
    pk.octets = 64'h0;
    for (int l = 0; l < 8; l++) begin
      k = l % 4;
      bus = (l < 4) ? fa_reg : fb_reg;
      case (pk.link_mode)
        // one octet, lane k carries sample k
        `SLTP_MODE_MIN: w = {8'(smp(bus, k) >> 4), 32'h0};
        // four 10 bit samples in five octets
        `SLTP_MODE_8B10B: w = {10'(smp(bus, k) >> 2), 10'(smp(bus, k + 4) >> 2),
                               10'(smp(bus, k + 8) >> 2), 10'(smp(bus, k + 12) >> 2)};
        // lane pairs per channel, even/odd samples
        `SLTP_MODE_QUAD: begin
          case (l / 2)
            0: bus = fa_reg;
            1: bus = fb_reg;
            2: bus = fc_reg;
            default: bus = fd_reg;
          endcase
          w = {smp(bus, l % 2), smp(bus, (l % 2) + 2), 16'h0};
        end
        default: w = {smp(bus, k), smp(bus, k + 4), 16'h0};
      endcase
      pk.octets[8 * l +: 8] = w[8 * (4 - int'(oct_sel)) +: 8];
    end
  end

  assign pk.take = take_reg;
  assign pk.oct_idx = idx_reg;

endmodule : sltp_packer

// File: verilog/sltp_lanes.sv
// lane map, test pattern mux, power control and register slave
//
// Summary of operation
// - Mode 12: one octet per lane, D0-D3 channel A, D4-D7 channel B.
// - Mode 13: four 10-bit samples in five octets per lane.
// - Mode 14: lane pairs per channel, even lane samples 0,2, odd 1,3.
// - Mode 15: lane k carries samples k and k+4, three octets.
// - Only CRC-12 is offered for the sync header check, never CRC-3.
// - FEC mode is selectable instead of CRC in the sync header.
// - Alternate lanes allowed only when four or fewer lanes are used.
// - Alternate select 0 drives D3-D0, 1 drives D7-D4, never both.
// - Powerdown pin high or full powerdown setting disables lane drivers.
// - Configuration registers keep their contents through powerdown.
// - After powerdown the link restarts and stale data is withheld.
// - Test select picks the pattern; lane count follows the link mode.
// - PRBS modes bypass transport and link layers, no scrambling or encoding.
// - PRBS7 bit is XOR of bits six and seven back.
// - PRBS9, 15, 23, 31 with their tap pairs.
// - Each lane's PRBS starts from a distinct seed phase.
// - Clock pattern sends eight ones then eight zeros, bypassing both layers.
// - Ramp: shared octet count, zero at multiframe start, wraps after 0xFF.
// - Ramp waits for lane alignment in 8b/10b, serializer ready otherwise.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "sltp_defs.svh"
module sltp_lanes (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic powerdown_input,
  input wire logic [191:0] sample_a,
  input wire logic [191:0] sample_b,
  input wire logic [47:0] sample_c,
  input wire logic [47:0] sample_d,
  output logic sample_take,
  input wire logic mf_start,
  input wire logic ilas_done,
  input wire logic serdes_ready,
  output logic [63:0] lane_octets,
  output logic [7:0] lane_drv_en,
  output logic lane_valid,
  output logic encode_bypass,
  output logic sh_fec_sel,
  output logic link_enable,
  output logic link_restart,
  output logic [1:0] channel_pair_enable
);

  sltp_pack_if pk ();

  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic pd_s1_reg;
  logic pd_s2_reg;
  logic pd_s3_reg;
  logic pd_pin_reg;
  sltp_pkg::sltp_pwr_t pwr_reg;
  sltp_pkg::sltp_pwr_t pwr_next;
  logic [7:0] flush_reg;
  logic [2:0] test_prev_reg;
  logic clk_phase_reg;
  logic ramp_run_reg;
  logic [7:0] ramp_reg;
  logic [7:0] ramp_oct;
  logic [63:0] prbs_oct;
  logic [63:0] mux_oct;
  logic [7:0] base_mask;
  logic [3:0] link_mode_select;
  logic [2:0] lane_test_select;
  logic alternate_lane_select;
  logic [1:0] lane_count_sel;
  logic pd_any;
  logic alt_active;
  logic is_prbs;
  logic prbs_reload;
  logic [31:0] status_word;

  assign link_mode_select = ctrl_reg[`SLTP_F_MODE_MSB:`SLTP_F_MODE_LSB];
  assign lane_test_select = ctrl_reg[`SLTP_F_TEST_MSB:`SLTP_F_TEST_LSB];
  assign alternate_lane_select = ctrl_reg[`SLTP_F_ALT];
  assign lane_count_sel = ctrl_reg[`SLTP_F_LANES_MSB:`SLTP_F_LANES_LSB];

  // lane mask from link mode; only mode 14 has a two lane option
  function automatic logic [7:0] lanes_of(input logic [3:0] m, input logic [1:0] c);
    if (c == `SLTP_LANES_8) begin
      lanes_of = 8'hFF;
    end else if (c == `SLTP_LANES_2 && m == `SLTP_MODE_QUAD) begin
      lanes_of = 8'h03;
    end else begin
      lanes_of = 8'h0F;
    end
  endfunction : lanes_of

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `SLTP_ADDR_CTRL) || (a == `SLTP_ADDR_STATUS);
  endfunction : mapped

  // byte strobes applied, unsupported link modes keep the old value
  always_comb begin
    logic [31:0] m;
    m = ctrl_reg;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_reg[b]) begin
        m[8 * b +: 8] = wdata_reg[8 * b +: 8];
      end
    end
    m = m & `SLTP_CTRL_MASK;
    if (m[`SLTP_F_MODE_MSB:`SLTP_F_MODE_LSB] < `SLTP_MODE_MIN) begin
      m[`SLTP_F_MODE_MSB:`SLTP_F_MODE_LSB] = link_mode_select;
    end
    ctrl_next = m;
  end

  // write channels taken in either order, one write outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLTP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_reg) ? `SLTP_RESP_OKAY : `SLTP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control register; powerdown never touches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `SLTP_CTRL_RESET;
    end else if (aw_full_reg && w_full_reg && !s_axi_bvalid
                 && awaddr_reg == `SLTP_ADDR_CTRL) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign status_word = {16'h0000, lane_drv_en, 1'b0, ramp_run_reg, alt_active,
                        pd_pin_reg, pwr_reg == sltp_pkg::SLTP_PWR_FLUSH,
                        pwr_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SLTP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `SLTP_ADDR_CTRL: begin
          s_axi_rdata <= ctrl_reg;
          s_axi_rresp <= `SLTP_RESP_OKAY;
        end
        `SLTP_ADDR_STATUS: begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `SLTP_RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SLTP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_s1_reg <= 1'b0;
      pd_s2_reg <= 1'b0;
      pd_s3_reg <= 1'b0;
      pd_pin_reg <= 1'b0;
    end else begin
      pd_s1_reg <= powerdown_input;
      pd_s2_reg <= pd_s1_reg;
      pd_s3_reg <= pd_s2_reg;
      if (pd_s2_reg == pd_s3_reg) begin
        pd_pin_reg <= pd_s3_reg;
      end
    end
  end

  assign pd_any = pd_pin_reg || ctrl_reg[`SLTP_F_FULL_PD];

  always_comb begin
    case (pwr_reg)
      sltp_pkg::SLTP_PWR_RUN: pwr_next = pd_any ? sltp_pkg::SLTP_PWR_DOWN : pwr_reg;
      sltp_pkg::SLTP_PWR_DOWN: pwr_next = pd_any ? pwr_reg : sltp_pkg::SLTP_PWR_FLUSH;
      sltp_pkg::SLTP_PWR_FLUSH: begin
        if (pd_any) begin
          pwr_next = sltp_pkg::SLTP_PWR_DOWN;
        end else if (flush_reg == 8'd0) begin
          pwr_next = sltp_pkg::SLTP_PWR_RUN;
        end else begin
          pwr_next = pwr_reg;
        end
      end
      default: pwr_next = sltp_pkg::SLTP_PWR_DOWN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= sltp_pkg::SLTP_PWR_RUN;
      flush_reg <= 8'd0;
      link_restart <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      // restart pulse and flush wait on leaving powerdown
      link_restart <= (pwr_reg == sltp_pkg::SLTP_PWR_DOWN) && !pd_any;
      if (pwr_reg == sltp_pkg::SLTP_PWR_DOWN) begin
        flush_reg <= 8'(`SLTP_FLUSH_CYC - 1);
      end else if (flush_reg != 8'd0) begin
        flush_reg <= flush_reg - 8'd1;
      end
    end
  end

  // alternate group only with four lanes or fewer
  assign alt_active = alternate_lane_select && (lane_count_sel != `SLTP_LANES_8);
  // powered lanes follow the link mode in every test mode
  assign base_mask = lanes_of(link_mode_select, lane_count_sel);
  assign is_prbs = (lane_test_select >= sltp_pkg::SLTP_TEST_PRBS7)
                   && (lane_test_select <= sltp_pkg::SLTP_TEST_PRBS31);
  assign prbs_reload = (lane_test_select != test_prev_reg)
                       || (pwr_reg != sltp_pkg::SLTP_PWR_RUN);

  // packer only runs with no test selected
  assign pk.link_mode = link_mode_select;
  assign pk.run = (pwr_reg == sltp_pkg::SLTP_PWR_RUN) && ctrl_reg[`SLTP_F_LINK_EN]
                  && (lane_test_select == sltp_pkg::SLTP_TEST_NONE);

  sltp_packer u_packer (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_a(sample_a),
    .sample_b(sample_b),
    .sample_c(sample_c),
    .sample_d(sample_d),
    .pk(pk)
  );

  generate
    for (genvar g = 0; g < 8; g++) begin : g_prbs
      // distinct nonzero seeds give distinct phases of one sequence
      sltp_prbs #(
        .SEED(31'(32'h0101_0101 * (g + 1)))
      ) u_prbs (
        .aclk(aclk),
        .aresetn(aresetn),
        .reload(prbs_reload),
        .advance(is_prbs),
        .sel(lane_test_select),
        .octet(prbs_oct[8 * g +: 8])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_prev_reg <= sltp_pkg::SLTP_TEST_NONE;
      clk_phase_reg <= 1'b0;
    end else begin
      test_prev_reg <= lane_test_select;
      clk_phase_reg <= (lane_test_select == sltp_pkg::SLTP_TEST_CLOCK) && !clk_phase_reg;
    end
  end

  // octet at multiframe start is zero, 8 bit counter wraps
  assign ramp_oct = mf_start ? 8'h00 : ramp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_run_reg <= 1'b0;
      ramp_reg <= 8'h00;
    end else if (lane_test_select != sltp_pkg::SLTP_TEST_RAMP
                 || pwr_reg != sltp_pkg::SLTP_PWR_RUN) begin
      ramp_run_reg <= 1'b0;
      ramp_reg <= 8'h00;
    end else if (!ramp_run_reg) begin
      // alignment done for 8b/10b, serializers ready otherwise
      ramp_run_reg <= (link_mode_select == `SLTP_MODE_8B10B) ? ilas_done : serdes_ready;
    end else begin
      ramp_reg <= ramp_oct + 8'h01;
    end
  end

  always_comb begin
    case (lane_test_select)
      // ff then 00, sixteen bit period
      sltp_pkg::SLTP_TEST_CLOCK: mux_oct = clk_phase_reg ? 64'h0 : {8{8'hFF}};
      sltp_pkg::SLTP_TEST_RAMP: mux_oct = {8{ramp_oct}};
      sltp_pkg::SLTP_TEST_NONE: mux_oct = pk.octets;
      default: mux_oct = prbs_oct;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_octets <= 64'h0;
      lane_drv_en <= 8'h00;
      lane_valid <= 1'b0;
      encode_bypass <= 1'b0;
      sh_fec_sel <= 1'b0;
      link_enable <= 1'b0;
      sample_take <= 1'b0;
      channel_pair_enable <= 2'h3;
    end else begin
      // one group only; upper group takes the lower lanes' data
      lane_octets <= alt_active ? {mux_oct[31:0], 32'h0} : mux_oct;
      lane_drv_en <= pd_any ? 8'h00 : (alt_active ? {base_mask[3:0], 4'h0} : base_mask);
      // nothing valid until the flush wait ends
      lane_valid <= (pwr_reg == sltp_pkg::SLTP_PWR_RUN) && !pd_any
                    && (lane_test_select != sltp_pkg::SLTP_TEST_NONE
                        || (pk.run && pk.take) || (pk.run && pk.oct_idx != 3'd0));
      // prbs and clock pattern skip scrambler and encoder
      encode_bypass <= is_prbs || (lane_test_select == sltp_pkg::SLTP_TEST_CLOCK);
      // crc-12 unless fec chosen; no crc-3 choice exists
      sh_fec_sel <= ctrl_reg[`SLTP_F_FEC];
      // link held off while a bypass pattern runs
      link_enable <= ctrl_reg[`SLTP_F_LINK_EN] && !pd_any
                     && (pwr_reg == sltp_pkg::SLTP_PWR_RUN)
                     && !is_prbs && (lane_test_select != sltp_pkg::SLTP_TEST_CLOCK);
      sample_take <= pk.take;
      // stored as written; all off is software's fault
      channel_pair_enable <= ctrl_reg[`SLTP_F_CHEN_MSB:`SLTP_F_CHEN_LSB];
    end
  end

endmodule : sltp_lanes

// File: dv/sltp_rx_model.sv
// receiver side model: link bring-up status and multiframe starts
`timescale 1ns/100ps
module sltp_rx_model #(
  parameter int MF = 400
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_enable,
  input wire logic link_restart,
  output logic mf_start,
  output logic ilas_done,
  output logic serdes_ready
);
  int cnt = 0;
  initial {mf_start, ilas_done, serdes_ready} = 3'h0;
  // bring-up starts over when the link drops or powerdown ends
  // alignment finishes only after the serializers are up
  always @(posedge aclk) begin
    if (!aresetn || !link_enable || link_restart) begin
      cnt <= 0;
      {mf_start, ilas_done, serdes_ready} <= 3'h0;
    end else begin
      cnt <= cnt + 1;
      serdes_ready <= cnt > 15;
      ilas_done <= cnt > 40;
      mf_start <= cnt % MF == 40;
    end
  end
endmodule : sltp_rx_model

// File: dv/sltp_lanes_checker.sv
// port assertions for the lane block
`timescale 1ns/100ps
module sltp_lanes_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic powerdown_input,
  input wire logic [7:0] lane_drv_en,
  input wire logic lane_valid,
  input wire logic link_restart
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // long enough to pass the pin synchronizer
  sequence pd_held;
    powerdown_input [*8];
  endsequence
  sequence flush_quiet;
    !lane_valid [*8];
  endsequence
  chk_pd_drv_off: assert property (pd_held |-> lane_drv_en == 8'h00 && !lane_valid)
    else $error("lanes driven in powerdown");
  chk_restart_due: assert property (pd_held ##1 !powerdown_input |-> ##[0:12] link_restart)
    else $error("no restart after powerdown");
  chk_flush_quiet: assert property (link_restart |-> flush_quiet)
    else $error("stale data after powerdown");
  chk_restart_pulse: assert property (link_restart |=> !link_restart)
    else $error("restart not a pulse");
  chk_valid_drv: assert property (lane_valid |-> lane_drv_en != 8'h00)
    else $error("valid data on undriven lanes");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("late write response");
  chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("late read response");
endmodule : sltp_lanes_checker
bind sltp_lanes sltp_lanes_checker u_sltp_lanes_checker (.*);

// File: dv/tb_top.sv
// self-checking bench for lane map and test patterns
`timescale 1ns/100ps
`include "sltp_defs.svh"
module tb_top;
  logic aclk = '0, aresetn = '0, powerdown_input = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, lane_drv_en, cur, prv;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, channel_pair_enable, rrsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_take, mf_start, ilas_done, serdes_ready, lane_valid, encode_bypass;
  logic sh_fec_sel, link_enable, link_restart;
  logic [191:0] sample_a = '0, sample_b = '0;
  logic [47:0] sample_c = '0, sample_d = '0;
  logic [63:0] lane_octets, v0, v1;
  int mismatches = 0, checks = 0, n;
  int tap_a [5] = '{6, 5, 14, 18, 28};
  int tap_b [5] = '{7, 9, 15, 23, 31};
  always #12.5 aclk = ~aclk;
  sltp_lanes u_sltp_lanes (.*);
  sltp_rx_model u_sltp_rx_model (.*);
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic results;
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= `SLTP_ADDR_CTRL;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    s_axi_bready <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= '0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= '0;
  endtask : rd
  function automatic logic [31:0] cw(input int m, t, a, l, f, e, p);
    return {16'h0000, 2'h3, 1'h0, e[0], p[0], f[0], l[1:0], a[0], t[2:0], m[3:0]};
  endfunction : cw
  function automatic logic [11:0] smp(input int c, input int j);
    case (c)
      0: return sample_a[12 * j +: 12];
      1: return sample_b[12 * j +: 12];
      2: return sample_c[12 * (j % 4) +: 12];
      default: return sample_d[12 * (j % 4) +: 12];
    endcase
  endfunction : smp
  // octet i of lane l, first octet sent first
  function automatic logic [7:0] eo(input int m, input int l, input int i);
    logic [11:0] s [4];
    logic [39:0] w;
    for (int j = 0; j < 4; j++) begin
      s[j] = (m == 14) ? smp(l / 2, l % 2 + 2 * j) : smp(l / 4, l % 4 + 4 * j);
    end
    case (m)
      12: w = {s[0][11:4], 32'h0000_0000};
      13: w = {s[0][11:2], s[1][11:2], s[2][11:2], s[3][11:2]};
      default: w = {s[0], s[1], 16'h0000};
    endcase
    return w[39 - 8 * i -: 8];
  endfunction : eo
  task automatic grab;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      v0[63 - 8 * i -: 8] = lane_octets[7:0];
      v1[63 - 8 * i -: 8] = lane_octets[15:8];
    end
  endtask : grab
  task automatic sync;
    n = 0;
    do @(posedge aclk); while (!sample_take && ++n < 100);
  endtask : sync
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results;
  end
  initial begin
    void'($urandom(32'ha008_b66c));
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    rd(`SLTP_ADDR_CTRL);
    cmp(rdat, `SLTP_CTRL_RESET);
    rd(8'h08);
    cmp(rrsp, `SLTP_RESP_SLVERR);
    // channel pairs stay on; mode tests run with the link enabled
    for (int m = 12; m < 16; m++) begin
      @(posedge aclk);
      for (int j = 0; j < 6; j++) begin
        sample_a[32 * j +: 32] <= $urandom;
        sample_b[32 * j +: 32] <= $urandom;
      end
      sample_c <= 48'({$urandom, $urandom});
      sample_d <= 48'({$urandom, $urandom});
      wr(cw(m, 0, 0, 0, 0, 1, 0));
      sync;
      sync;
      for (int i = 0; i < ((m == 12) ? 1 : (m == 13) ? 5 : 3); i++) begin
        for (int l = 0; l < 8; l++) cmp(lane_octets[8 * l +: 8], eo(m, l, i));
        @(posedge aclk);
      end
    end
    for (int j = 0; j < 4; j++) begin
      wr(cw(15, j / 3, j == 1 || j == 2, j != 2, 0, j != 3, 0));
      repeat (4) @(posedge aclk);
      cmp(lane_drv_en, (j == 1) ? 8'hF0 : (j == 2) ? 8'hFF : 8'h0F);
      cmp(lane_octets[31:0] == 32'h0, j == 1);
    end
    for (int j = 1; j >= 0; j--) begin
      wr(cw(15, 0, 0, 0, j, 1, 0));
      repeat (2) @(posedge aclk);
      cmp(sh_fec_sel, j[0]);
    end
    for (int t = 1; t < 7; t++) begin
      wr(cw(15, t, 0, 0, 0, 0, 0));
      repeat (4) @(posedge aclk);
      grab;
      cmp({encode_bypass, link_enable}, 2'h2);
      cmp(v0 == v1, t == 6);
      for (int b = 8; b < 64 && t == 6; b += 8) begin
        cmp(v0[71 - b -: 16] == 16'hFF00 || v0[71 - b -: 16] == 16'h00FF, 1);
      end
      for (int b = (t < 6) ? tap_b[t - 1] : 64; b < 64; b++) begin
        cmp(v0[63 - b], v0[63 - b + tap_a[t - 1]] ^ v0[63 - b + tap_b[t - 1]]);
      end
    end
    wr(cw(15, 7, 0, 0, 0, 0, 0));
    wr(cw(15, 7, 0, 0, 0, 1, 0));
    rd(`SLTP_ADDR_STATUS);
    cmp(rdat[6], 0);
    repeat (40) @(posedge aclk);
    rd(`SLTP_ADDR_STATUS);
    cmp(rdat[6], 1);
    for (int i = 0; i < 300; i++) begin
      @(posedge aclk);
      cur = lane_octets[7:0];
      cmp(lane_octets, {8{cur}});
      if (i > 0 && cur !== 8'h00) cmp(cur, prv + 8'h01);
      prv = cur;
    end
    powerdown_input <= '1;
    repeat (8) @(posedge aclk);
    cmp({lane_drv_en, lane_valid}, 9'h000);
    powerdown_input <= '0;
    n = 0;
    do @(posedge aclk); while (!link_restart && ++n < 20);
    cmp(n < 20, 1);
    rd(`SLTP_ADDR_CTRL);
    cmp(rdat, cw(15, 7, 0, 0, 0, 1, 0));
    cmp(channel_pair_enable, 2'h3);
    wr(cw(15, 0, 0, 0, 0, 1, 1));
    repeat (8) @(posedge aclk);
    cmp(lane_drv_en, 8'h00);
    results;
  end
endmodule : tb_top
